/* File: hdl/conv_pkg.sv */
package conv_pkg;

    // ****************************************
    // Register indices (byte addresses on the plain port)
    // ****************************************
    localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
    localparam logic [3:0] ADDR_CONTROL_C = 4'h2;
    localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
    localparam logic [3:0] ADDR_RESULT_HIGH = 4'h4;
    localparam logic [3:0] ADDR_PIN_SHARE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_POWER = 5;
    localparam int BIT_ALIGN = 4;
    localparam int BIT_AMP_EN = 7;
    localparam int BIT_BG_EN = 6;

    // Write masks of implemented bits; the rest read as zero
    localparam logic [7:0] MASK_CONTROL_A = 8'hF3;
    localparam logic [7:0] MASK_CONTROL_B = 8'hE7;
    localparam logic [7:0] MASK_CONTROL_C = 8'hCF;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [3:0] RESET_PIN_SHARE = 4'h0;
    localparam logic [11:0] RESET_RESULT = 12'h000;

    // ****************************************
    // Counts
    // ****************************************
    localparam int RESULT_BITS = 12;
    localparam int CHANNELS = 4;
    // Converter clock periods per conversion, one per result bit plus sample and done
    localparam int CONV_CLOCKS = 14;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0]
    {
        SRC_EXTERNAL,
        SRC_SUPPLY,
        SRC_AMPLIFIER
    } source_e;

    typedef enum logic [1:0]
    {
        REF_SUPPLY,
        REF_EXTERNAL,
        REF_BANDGAP
    } reference_e;

    // Analog routing toward the converter core
    typedef struct packed
    {
        source_e source;
        logic [1:0] channel;
        logic [1:0] supply_scale;
        logic [1:0] amp_scale;
        reference_e reference;
        logic [1:0] ref_gain;
        logic amp_enable;
        logic bandgap_enable;
        logic power_enable;
    } analog_route_s;

endpackage

/* File: hdl/conv_clock_div.sv */
`timescale 1ns/10ps
module conv_clock_div
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [2:0] select,
    // Output
    output logic tick
);
    import conv_pkg::*;

    logic [6:0] count;
    logic [6:0] limit;
    logic [6:0] next_count;

    // Divide by two to the power of select; select 0 ticks every cycle
    assign limit = 7'((8'h01 << select) - 8'h01);
    assign tick = run && (count == limit);
    assign next_count = tick ? 7'h00 : 7'(count + 7'h01);

    // Counter held at zero while idle so the first period is always whole
    always_ff @(posedge clock)
    begin
        if (rst || !run)
            count <= 7'h00;
        else
            count <= next_count;
    end
endmodule

/* File: hdl/conv_sar_sequencer.sv */
`timescale 1ns/10ps
module conv_sar_sequencer
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic reset_core,
    input wire logic begin_conv,
    input wire logic tick,
    // Core comparator side
    input wire logic compare_high,
    output logic [11:0] trial,
    // Status
    output logic running,
    output logic done,
    output logic [11:0] value
);
    import conv_pkg::*;

    logic [3:0] step;
    logic [11:0] bits;
    logic [11:0] mask;

    // One-hot mask of the bit under trial
    assign mask = (step < 4'(RESULT_BITS)) ? 12'(12'h800 >> step) : 12'h000;
    assign trial = bits | mask;
    assign done = running && tick && (step == 4'(CONV_CLOCKS - 1));
    assign value = bits;

    // Successive approximation, one bit per converter clock
    always_ff @(posedge clock)
    begin
        if (rst || reset_core)
        begin
            running <= 1'b0;
            step <= 4'h0;
            bits <= 12'h000;
        end
        else if (begin_conv)
        begin
            running <= 1'b1;
            step <= 4'h0;
            bits <= 12'h000;
        end
        else if (running && tick)
        begin
            if (step < 4'(RESULT_BITS) && compare_high)
                bits <= bits | mask;
            step <= 4'(step + 4'h1);
            if (done)
                running <= 1'b0;
        end
    end
endmodule

/* File: hdl/conv_control.sv */
`timescale 1ns/10ps
// Function
// - Result is twelve bits, two byte registers
// - Alignment picks left or right justified bytes
// - Unused result bits always read zero
// - Power off keeps result registers intact
// - Channel field picks one of four pins
// - Source zero routes chosen external pin
// - Sources one to three route supply
// - Sources five to seven route amplifier
// - Internal source wins over external pin
// - Bandgap reference wins over external reference
// - Pin share bits make pins analog
// - Analog pins drop their pull-high
// - Three eight-bit control registers govern converter
// - Start rise resets, fall begins conversion
// - Completion clears busy, raises interrupt
// - Clock select divides by power two
module conv_control
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [3:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    // Converter core
    input wire logic compare_high,
    output logic [11:0] trial_code,
    output logic sample,
    output conv_pkg::analog_route_s route,
    // Port pins
    output logic [3:0] analog_input_pins,
    output logic [3:0] pull_high_allow,
    // Interrupt
    output logic irq
);
    import conv_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] conv_control_a;
    logic [7:0] conv_control_b;
    logic [7:0] conv_control_c;
    logic [3:0] port_pin_share_select;
    logic [11:0] result;
    logic conversion_busy_flag;
    logic irq_status;
    logic irq_enable;
    logic start_prev;

    // ****************************************
    // Decode
    // ****************************************
    wire write_a = write_strobe && (address == ADDR_CONTROL_A);
    wire write_b = write_strobe && (address == ADDR_CONTROL_B);
    wire write_c = write_strobe && (address == ADDR_CONTROL_C);
    wire write_share = write_strobe && (address == ADDR_PIN_SHARE);
    wire write_ien = write_strobe && (address == ADDR_IRQ_ENABLE);
    wire write_iclr = write_strobe && (address == ADDR_IRQ_CLEAR);

    // Field views
    wire start_bit = conv_control_a[BIT_START];
    wire converter_power_enable = conv_control_a[BIT_POWER];
    wire result_alignment_select = conv_control_a[BIT_ALIGN];
    wire [1:0] external_channel_select = conv_control_a[1:0];
    wire [2:0] internal_source_select = conv_control_b[7:5];
    wire [2:0] converter_clock_select = conv_control_b[2:0];
    wire amplifier_enable = conv_control_c[BIT_AMP_EN];
    wire bandgap_buffer_enable = conv_control_c[BIT_BG_EN];
    wire [3:0] reference_source_select = conv_control_c[3:0];

    // ****************************************
    // Start edges
    // ****************************************
    // Edges are taken from the stored bit, so one write makes one edge
    wire start_rise = start_bit && !start_prev;
    wire start_fall = !start_bit && start_prev;
    wire conv_tick;
    wire conv_done;
    wire conv_running;
    wire [11:0] conv_value;

    // Copy of the stored start bit from the cycle before
    always_ff @(posedge clock)
    begin
        if (rst)
            start_prev <= 1'b0;
        else
            start_prev <= start_bit;
    end

    // ****************************************
    // Completion
    // ****************************************
    // A finish that meets a start edge or a power drop is void: the edge
    // restarts or aborts the core, so neither result nor flags may move.
    // Without this a late finish would raise the interrupt over a stale result.
    wire conv_complete = conv_done && converter_power_enable && !start_rise && !start_fall;

    // ****************************************
    // Divider and sequencer
    // ****************************************
    conv_clock_div u_div
    (
        .clock(clock),
        .rst(rst),
        .run(conv_running),
        .select(converter_clock_select),
        .tick(conv_tick)
    );

    conv_sar_sequencer u_seq
    (
        .clock(clock),
        .rst(rst),
        .reset_core(start_rise || !converter_power_enable),
        .begin_conv(start_fall && converter_power_enable),
        .tick(conv_tick),
        .compare_high(compare_high),
        .trial(trial_code),
        .running(conv_running),
        .done(conv_done),
        .value(conv_value)
    );

    assign sample = conv_running;

    // ****************************************
    // Control registers
    // ****************************************
    // Busy bit is hardware owned; bit 6 of a write is stored but reads back as busy
    always_ff @(posedge clock)
    begin
        if (rst)
            conv_control_a <= RESET_CONTROL;
        else if (write_a)
            conv_control_a <= write_data & MASK_CONTROL_A;
    end

    // Unimplemented bits are masked on the way in, so reads need no mask
    always_ff @(posedge clock)
    begin
        if (rst)
            conv_control_b <= RESET_CONTROL;
        else if (write_b)
            conv_control_b <= write_data & MASK_CONTROL_B;
    end

    // Reference code and the two analog enables
    always_ff @(posedge clock)
    begin
        if (rst)
            conv_control_c <= RESET_CONTROL;
        else if (write_c)
            conv_control_c <= write_data & MASK_CONTROL_C;
    end

    // Pin share bits; the upper nibble of the write is ignored
    always_ff @(posedge clock)
    begin
        if (rst)
            port_pin_share_select <= RESET_PIN_SHARE;
        else if (write_share)
            port_pin_share_select <= write_data[3:0];
    end

    // ****************************************
    // Busy, result and interrupt
    // ****************************************
    // Busy follows the start edges; power off aborts and clears it
    always_ff @(posedge clock)
    begin
        if (rst)
            conversion_busy_flag <= 1'b0;
        else if (start_rise || !converter_power_enable)
            conversion_busy_flag <= 1'b0;
        else if (start_fall)
            conversion_busy_flag <= 1'b1;
        else if (conv_complete)
            conversion_busy_flag <= 1'b0;
    end

    // Result is kept across power down; only a finished conversion moves it,
    // on the same edge that drops busy, so a poller never sees a half result
    always_ff @(posedge clock)
    begin
        if (rst)
            result <= RESET_RESULT;
        else if (conv_complete)
            result <= conv_value;
    end

    // Completion in the same cycle as a clear keeps the flag set
    always_ff @(posedge clock)
    begin
        if (rst)
            irq_status <= 1'b0;
        else if (conv_complete)
            irq_status <= 1'b1;
        else if (write_iclr && write_data[0])
            irq_status <= 1'b0;
    end

    // Only bit 0 of the enable register is implemented
    always_ff @(posedge clock)
    begin
        if (rst)
            irq_enable <= 1'b0;
        else if (write_ien)
            irq_enable <= write_data[0];
    end

    // Level output, held until the status is cleared or masked
    assign irq = irq_status && irq_enable;

    // ****************************************
    // Result formatting
    // ****************************************
    // Left justified leaves low nibble zero, right justified top nibble zero
    wire [7:0] result_high = result_alignment_select ? {4'h0, result[11:8]}
                                                      : result[11:4];
    wire [7:0] result_low = result_alignment_select ? result[7:0]
                                                     : {result[3:0], 4'h0};

    // ****************************************
    // Read path
    // ****************************************
    // Read image of each register, unimplemented bits already zero
    wire [7:0] view_control_a = {conv_control_a[7], conversion_busy_flag, conv_control_a[5:0]};
    wire [7:0] view_pin_share = {4'h0, port_pin_share_select};
    wire [7:0] view_irq_status = {7'h00, irq_status};
    wire [7:0] view_irq_enable = {7'h00, irq_enable};

    // The clear register is write only and falls to the default zero
    logic [7:0] read_mux;
    always_comb
    begin
        case (address)
            ADDR_CONTROL_A: read_mux = view_control_a;
            ADDR_CONTROL_B: read_mux = conv_control_b;
            ADDR_CONTROL_C: read_mux = conv_control_c;
            ADDR_RESULT_LOW: read_mux = result_low;
            ADDR_RESULT_HIGH: read_mux = result_high;
            ADDR_PIN_SHARE: read_mux = view_pin_share;
            ADDR_IRQ_STATUS: read_mux = view_irq_status;
            ADDR_IRQ_ENABLE: read_mux = view_irq_enable;
            default: read_mux = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (rst || !read_strobe)
            read_data <= 8'h00;
        else
            read_data <= read_mux;
    end

    // ****************************************
    // Analog routing
    // ****************************************
    // Internal source codes override the pin; code 100 counts as external
    wire src_supply = (internal_source_select >= 3'h1) && (internal_source_select <= 3'h3);
    wire src_amp = (internal_source_select >= 3'h5);
    wire ref_ext = (reference_source_select >= 4'h1) && (reference_source_select <= 4'h4);
    wire ref_bg = (reference_source_select >= 4'hA) && (reference_source_select <= 4'hC);

    // Source and reference picks; the internal codes are tested first so they win
    source_e source_pick;
    reference_e reference_pick;
    assign source_pick = src_amp ? SRC_AMPLIFIER
                       : src_supply ? SRC_SUPPLY
                       : SRC_EXTERNAL;
    // Both requests at once settle on the bandgap
    assign reference_pick = ref_bg ? REF_BANDGAP
                          : ref_ext ? REF_EXTERNAL
                          : REF_SUPPLY;

    // Packing only; every choice is made above
    always_comb
    begin
        route.source = source_pick;
        route.channel = external_channel_select;
        route.supply_scale = internal_source_select[1:0];
        route.amp_scale = internal_source_select[1:0];
        route.reference = reference_pick;
        route.ref_gain = reference_source_select[1:0];
        // Amplifier is left to software; routing does not force it on
        route.amp_enable = amplifier_enable;
        route.bandgap_enable = bandgap_buffer_enable;
        route.power_enable = converter_power_enable;
    end

    // ****************************************
    // Pin sharing
    // ****************************************
    genvar pin;
    generate
        for (pin = 0; pin < CHANNELS; pin = pin + 1)
        begin : g_pin
            assign analog_input_pins[pin] = port_pin_share_select[pin];
            assign pull_high_allow[pin] = !port_pin_share_select[pin];
        end
    endgenerate

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The sequencer counts steps in four bits and needs two steps past the data
    if ((CONV_CLOCKS > 16) || (CONV_CLOCKS < RESULT_BITS + 2))
    begin : g_bad_length
        $error("conversion length does not fit the step counter");
    end

    // Pin vectors are four wide; another channel count needs new ports
    if (CHANNELS != 4)
    begin : g_bad_channels
        $error("channel count does not match the pin vectors");
    end
endmodule

/* File: testbench/conv_core_model.sv */
`timescale 1ns/10ps
// ****
// Comparator model of the converter core
// ****
module conv_core_model
#(
    parameter logic [47:0] PIN_LEVELS = 48'h801_000_FFF_5A3,
    parameter logic [11:0] SUPPLY_LEVEL = 12'hABC,
    parameter logic [11:0] AMP_LEVEL = 12'h3C7
)
(
    // Clock
    input wire logic clock,
    // Core side
    input wire conv_pkg::analog_route_s route,
    input wire logic [11:0] trial_code,
    output logic compare_high
);
    import conv_pkg::*;
    logic [11:0] level;
    logic usable;
    logic junk = 1'b0;
    // Internal sources win over the pins
    assign level = (route.source == SRC_SUPPLY) ? SUPPLY_LEVEL :
        (route.source == SRC_AMPLIFIER) ? AMP_LEVEL :
        PIN_LEVELS[route.channel*12 +: 12];
    // An unpowered comparator answers nothing useful, so it toggles
    always_ff @(posedge clock)
    begin
        junk <= ~junk;
    end
    // Amplifier path without its amplifier enabled is noise as well
    assign usable = route.power_enable
        && (route.source != SRC_AMPLIFIER || route.amp_enable);
    assign compare_high = usable ? (level >= trial_code) : junk;
endmodule

/* File: testbench/conv_control_sva.sv */
`timescale 1ns/10ps
// ****
// Port checker for the converter control block
// ****
module conv_control_sva
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [3:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [7:0] read_data,
    // Converter core
    input wire logic compare_high,
    input wire logic [11:0] trial_code,
    input wire logic sample,
    input wire conv_pkg::analog_route_s route,
    // Pins and interrupt
    input wire logic [3:0] analog_input_pins,
    input wire logic [3:0] pull_high_allow,
    input wire logic irq
);
    import conv_pkg::*;
    logic [11:0] run_len;
    logic wa, wb, wc;
    // Write decodes
    assign wa = write_strobe && address == ADDR_CONTROL_A;
    assign wb = write_strobe && address == ADDR_CONTROL_B;
    assign wc = write_strobe && address == ADDR_CONTROL_C;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // Sample phase length; slowest divider needs 14 x 128 cycles
    always_ff @(posedge clock)
    begin
        if (rst || !sample)
        begin
            run_len <= 12'h000;
        end
        else
        begin
            run_len <= run_len + 12'h001;
        end
    end
    AST_CHANNEL: assert property (wa |=> route.channel == $past(write_data[1:0]))
        else $error("channel not taken from control write");
    AST_SRC_EXT: assert property (wb && write_data[7:5] == 3'h0 |=> route.source == SRC_EXTERNAL)
        else $error("source zero does not route pin");
    AST_SRC_SUP: assert property (wb && write_data[7:5] inside {3'h1, 3'h2, 3'h3}
        |=> route.source == SRC_SUPPLY)
        else $error("supply source not routed");
    AST_SRC_AMP: assert property (wb && write_data[7:5] inside {3'h5, 3'h6, 3'h7}
        |=> route.source == SRC_AMPLIFIER)
        else $error("amplifier source not routed");
    AST_REF_BG: assert property (wc && write_data[3:0] inside {4'hA, 4'hB, 4'hC}
        |=> route.reference == REF_BANDGAP)
        else $error("bandgap reference not chosen");
    AST_UNMAPPED: assert property (read_strobe && address > ADDR_IRQ_CLEAR |=> read_data == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_IDLE: assert property (!$past(read_strobe) |-> read_data == 8'h00)
        else $error("read data outside read cycle");
    AST_PINS: assert property (write_strobe && address == ADDR_PIN_SHARE
        |=> analog_input_pins == $past(write_data[3:0]))
        else $error("pin share not applied");
    AST_PULL: assert property (pull_high_allow == ~analog_input_pins)
        else $error("pull-high kept on analog pin");
    AST_RUN_LEN: assert property (sample |-> run_len < 12'h708)
        else $error("conversion runs too long");
    AST_IRQ_OFF: assert property (write_strobe && address == ADDR_IRQ_ENABLE && !write_data[0]
        |=> !irq)
        else $error("interrupt high while disabled");
endmodule
bind conv_control conv_control_sva chk
(
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .compare_high(compare_high), .trial_code(trial_code), .sample(sample), .route(route),
    .analog_input_pins(analog_input_pins), .pull_high_allow(pull_high_allow), .irq(irq)
);

/* File: testbench/adc_control_and_result_regs_tb.sv */
`timescale 1ns/10ps
module adc_control_and_result_regs_tb;
    import conv_pkg::*;
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_s;
    localparam logic [47:0] PINS = 48'h801_000_FFF_5A3;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [7:0] read_data, got;
    logic compare_high, sample, irq;
    logic [11:0] trial_code;
    logic [3:0] pins, pulls;
    analog_route_s route;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // Register writes beside the value read back
    row_s rows [11] = '{'{ADDR_CONTROL_A, 8'h1F, 8'h13}, '{ADDR_CONTROL_A, 8'h40, 8'h00},
        '{ADDR_CONTROL_B, 8'hFF, 8'hE7}, '{ADDR_CONTROL_C, 8'hFF, 8'hCF},
        '{ADDR_CONTROL_C, 8'hCB, 8'hCB}, '{ADDR_RESULT_LOW, 8'hFF, 8'h00},
        '{ADDR_RESULT_HIGH, 8'hFF, 8'h00}, '{ADDR_IRQ_CLEAR, 8'hFF, 8'h00},
        '{4'hF, 8'hFF, 8'h00}, '{ADDR_PIN_SHARE, 8'hFF, 8'h0F}, '{ADDR_IRQ_ENABLE, 8'hFF, 8'h01}};
    conv_control dut (.clock(clock), .rst(rst), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .compare_high(compare_high), .trial_code(trial_code), .sample(sample), .route(route),
        .analog_input_pins(pins), .pull_high_allow(pulls), .irq(irq));
    conv_core_model #(.PIN_LEVELS(PINS), .SUPPLY_LEVEL(12'hABC), .AMP_LEVEL(12'h3C7)) model
        (.clock(clock), .route(route), .trial_code(trial_code), .compare_high(compare_high));
    // Clock at 10 MHz
    always #50 clock = ~clock;
    task automatic compare(input logic [7:0] got_v, input logic [7:0] exp_v);
        check_count++;
        if (got_v !== exp_v)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        got = read_data;
    endtask
    task automatic settle();
        @(posedge clock);
        #1;
    endtask
    // One conversion; sample length checked loosely around fourteen divider periods
    task automatic convert(input logic [2:0] src, input logic [1:0] ch, input logic al,
        input logic [2:0] sel, input logic [11:0] d);
        logic [7:0] ctl;
        int n;
        int k;
        int div;
        ctl = {2'b00, 1'b1, al, 2'b00, ch};
        n = 0;
        div = 1 << sel;
        wr(ADDR_CONTROL_B, {src, 2'b00, sel});
        wr(ADDR_CONTROL_A, ctl);
        settle();
        wr(ADDR_CONTROL_A, ctl | 8'h80);
        wr(ADDR_CONTROL_A, ctl);
        rd(ADDR_CONTROL_A);
        compare(got, ctl | 8'h40);
        for (k = 0; k < 4000 && irq !== 1'b1; k++)
        begin
            settle();
            n += int'(sample === 1'b1);
        end
        compare({7'h00, irq}, 8'h01);
        compare({7'h00, n >= 13 * div - 5 && n <= 15 * div + 3}, 8'h01);
        rd(ADDR_CONTROL_A);
        compare(got, ctl);
        rd(ADDR_RESULT_HIGH);
        compare(got, al ? {4'h0, d[11:8]} : d[11:4]);
        rd(ADDR_RESULT_LOW);
        compare(got, al ? d[7:0] : {d[3:0], 4'h0});
        wr(ADDR_IRQ_ENABLE, 8'h00);
        settle();
        compare({7'h00, irq}, 8'h00);
        rd(ADDR_IRQ_STATUS);
        compare(got, 8'h01);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        settle();
        compare({7'h00, irq}, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far above the expected run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            final_report();
        end
    end
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++)
        begin
            rd(4'(a));
            compare(got, 8'h00);
        end
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            compare(got, rows[i].exp);
        end
        compare({4'h0, pins}, 8'h0F);
        compare({4'h0, pulls}, 8'h00);
        compare({6'h00, route.reference}, {6'h00, REF_BANDGAP});
        for (int c = 0; c < 4; c++)
        begin
            convert(3'b000, 2'(c), c[0], 3'b000, PINS[c*12 +: 12]);
        end
        convert(3'b010, 2'b10, 1'b0, 3'b000, 12'hABC);
        wr(ADDR_CONTROL_C, 8'hCB);
        convert(3'b111, 2'b01, 1'b1, 3'b011, 12'h3C7);
        // Power off must not wipe the last result
        wr(ADDR_CONTROL_A, 8'h10);
        rd(ADDR_RESULT_LOW);
        compare(got, 8'hC7);
        rd(ADDR_RESULT_HIGH);
        compare(got, 8'h03);
        // A new start rise in mid conversion resets the converter
        wr(ADDR_CONTROL_A, 8'hA0);
        wr(ADDR_CONTROL_A, 8'h20);
        wr(ADDR_CONTROL_A, 8'hA0);
        rd(ADDR_CONTROL_A);
        compare(got, 8'hA0);
        // Start held high with power on: the aborted run must never finish
        repeat (200) @(posedge clock);
        rd(ADDR_IRQ_STATUS);
        compare(got, 8'h00);
        rd(ADDR_CONTROL_A);
        compare(got, 8'hA0);
        wr(ADDR_CONTROL_A, 8'h00);
        // Reset with the converter idle brings control and result back to zero
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(ADDR_CONTROL_C);
        compare(got, 8'h00);
        rd(ADDR_RESULT_HIGH);
        compare(got, 8'h00);
        final_report();
    end
endmodule
